/* core/hsfs_sync.sv */
// Two flip-flop synchroniser for all asynchronous pin levels.
// Assumes pins change freely relative to hclk.
`timescale 1ns/10ps
`default_nettype none

module hsfs_sync import hsfs_pkg::*; #(
  parameter hsfs_pins_t RST = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire hsfs_pins_t pins,
  output hsfs_pins_t synced
);

  typedef struct packed {
    hsfs_pins_t meta;
    hsfs_pins_t sync;
  } hsfs_sync_s_t;

  hsfs_sync_s_t s;
  hsfs_sync_s_t next_s;

  // First stage feeds only the second
  always_comb begin
    next_s.meta = pins;
    next_s.sync = s.meta;
  end

  // Register both stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{meta: RST, sync: RST};
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.sync;

endmodule // hsfs_sync

`default_nettype wire

/* core/hsfs_top.sv */
// Hot swap fault supervisor: gate control, power good, fault latch, retry,
// severe overcurrent filter, temperature sampling, AHB-Lite registers.
// Assumes analog comparators and ADC outside; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_defines.svh"

module hsfs_top import hsfs_pkg::*; #(
  parameter bit ENABLE_ACTIVE_LOW = 1'b0,
  parameter int unsigned RETRY_CYCLES = `HSFS_RETRY_S * `HSFS_CLK_HZ,
  parameter int unsigned GRACE_CYCLES = `HSFS_GRACE_MS * (`HSFS_CLK_HZ / 1000),
  parameter int unsigned TMP_PERIOD_CYCLES = `HSFS_TMP_PERIOD_MS * (`HSFS_CLK_HZ / 1000),
  parameter int unsigned TMP_SLOT_CYCLES = `HSFS_TMP_SLOT_US * (`HSFS_CLK_HZ / 1000000)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic undervoltage_input,
  input wire logic overvoltage_input,
  input wire logic power_good_sense_in,
  input wire logic gate_enh_in,
  input wire logic timer_upper_threshold,
  input wire logic timer_lower_threshold,
  input wire logic enable_in,
  input wire logic retry_strap_n,
  input wire logic [3:0] severe_oc_cmp,
  input wire logic [11:0] temp_adc_data,
  output logic gate_on,
  output logic gate_strong_pulldown,
  output logic gate_fast_pulldown,
  output logic severe_oc_limit,
  output logic fault_out_n,
  output logic power_good_out,
  output logic power_good_out_oe,
  output logic temp_adc_request
);

  // Filter lengths, both times rounded down
  localparam logic [7:0] FILT_SHORT =
    8'((`HSFS_SC_FILT_SHORT_NS * (`HSFS_CLK_HZ / 1000000)) / 1000);
  localparam logic [7:0] FILT_LONG =
    8'((`HSFS_SC_FILT_LONG_NS * (`HSFS_CLK_HZ / 1000000)) / 1000);

  typedef struct packed {
    hsfs_state_t st;
    logic rearm;
    logic [31:0] wcnt;
    logic [31:0] enh_cnt;
    logic [31:0] tcnt;
    logic tphase;
    logic [7:0] sc_cnt;
    logic sc_trip;
    logic en_d;
    logic op_on;
    logic [1:0] thr_sel;
    logic filt_long;
    logic [11:0] t_fault;
    logic [11:0] t_warn;
    logic [11:0] t_result;
    logic t_fresh;
    logic ot_active;
    hsfs_status_t stat;
    logic fault_n;
    logic pg;
    logic pg_pull;
    logic gate_on;
    logic gate_spd;
    logic gate_fpd;
    logic adc_req;
    logic dp_wr;
    logic [7:0] dp_ofs;
    logic [31:0] rdata;
    logic ready;
  } hsfs_top_s_t;

  localparam hsfs_top_s_t S_RST = '{
    st: ST_OFF, op_on: `HSFS_RST_OP, t_fault: `HSFS_RST_TFAULT,
    t_warn: `HSFS_RST_TWARN, fault_n: 1'b1, pg_pull: 1'b1, ready: 1'b1,
    default: '0};

  // Strap resets high for latch-off; supply and enable reset to their quiet levels
  localparam hsfs_pins_t PINS_RST = '{uv_ok: 1'b1, retry_n: 1'b1,
    enable_raw: ENABLE_ACTIVE_LOW, default: '0};

  hsfs_top_s_t s;
  hsfs_top_s_t next_s;
  hsfs_pins_t pins;
  hsfs_pins_t c;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  assign pins = '{uv_ok: undervoltage_input, ov_hi: overvoltage_input,
    power_good_sense_in_ok: power_good_sense_in, enh_ok: gate_enh_in,
    timer_hi: timer_upper_threshold, timer_lo: timer_lower_threshold,
    enable_raw: enable_in, retry_n: retry_strap_n, sc_cmp: severe_oc_cmp};

  hsfs_sync #(.RST(PINS_RST)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins(pins),
    .synced(c)
  );

  //////////////////////////////////////////////////////////////////////////
  // Supervisor next state
  always_comb begin
    logic en_lvl;
    logic en_rise;
    logic uv_bad;
    logic ov_bad;
    logic ap_ok;
    logic op_rise;
    logic clr_cmd;
    logic pcyc;
    logic sc_sel;
    logic oc_ev;
    logic fet_ev;
    logic ot_ev;
    logic shut;
    logic pg_base;
    logic start_ok;
    logic [7:0] flen;
    next_s = s;
    en_lvl = ENABLE_ACTIVE_LOW ? ~c.enable_raw : c.enable_raw;
    en_rise = en_lvl & ~s.en_d;
    next_s.en_d = en_lvl;
    uv_bad = ~c.uv_ok;
    ov_bad = c.ov_hi;
    op_rise = 1'b0;
    clr_cmd = 1'b0;
    pcyc = 1'b0;
    fet_ev = 1'b0;

    // AHB address phase, read data loaded for the data phase
    ap_ok = hsel & htrans[1] & hready & (hsize == 3'b010) & (haddr[1:0] == 2'b00);
    next_s.dp_wr = ap_ok & hwrite & (haddr[31:8] == 24'h00_0000);
    next_s.dp_ofs = haddr[7:0];
    if (ap_ok && !hwrite) begin
      next_s.rdata = '0;
      if (haddr[31:8] == '0) begin
        case (haddr[7:0])
          `HSFS_OFS_CTRL: next_s.rdata = 32'({s.filt_long, s.thr_sel, 2'b00, s.op_on});
          `HSFS_OFS_TFAULT: next_s.rdata = 32'(s.t_fault);
          `HSFS_OFS_TWARN: next_s.rdata = 32'(s.t_warn);
          `HSFS_OFS_TEMP: begin
            next_s.rdata = 32'({s.t_fresh, s.t_result});
            next_s.t_fresh = 1'b0; // Read clears fresh
          end
          `HSFS_OFS_STATUS: next_s.rdata = 32'(s.stat);
          `HSFS_OFS_LIVE: next_s.rdata = 32'({s.ot_active, s.st, s.gate_on,
            s.fault_n, s.pg});
          default: next_s.rdata = '0;
        endcase
      end
    end

    // AHB data phase writes
    if (s.dp_wr) begin
      case (s.dp_ofs)
        `HSFS_OFS_CTRL: begin
          next_s.op_on = hwdata[`HSFS_CTRL_OP];
          op_rise = hwdata[`HSFS_CTRL_OP] & ~s.op_on;
          clr_cmd = hwdata[`HSFS_CTRL_CLR];
          pcyc = hwdata[`HSFS_CTRL_PCYC];
          next_s.thr_sel = hwdata[`HSFS_CTRL_THR_LSB +: 2];
          next_s.filt_long = hwdata[`HSFS_CTRL_FILT];
        end
        `HSFS_OFS_TFAULT: next_s.t_fault = hwdata[11:0];
        `HSFS_OFS_TWARN: next_s.t_warn = hwdata[11:0];
        default: ;
      endcase
    end

    // Severe overcurrent glitch filter
    sc_sel = c.sc_cmp[s.thr_sel];
    flen = s.filt_long ? FILT_LONG : FILT_SHORT;
    if (sc_sel) begin
      if (s.sc_cnt != 8'hFF) next_s.sc_cnt = s.sc_cnt + 8'd1;
    end else begin
      next_s.sc_cnt = '0;
    end
    next_s.sc_trip = sc_sel & ({1'b0, s.sc_cnt} + 9'd1 >= {1'b0, flen});

    // Temperature converter slot and result every second slot
    if (s.tcnt == TMP_PERIOD_CYCLES - 1) next_s.tcnt = '0;
    else next_s.tcnt = s.tcnt + 32'd1;
    next_s.adc_req = next_s.tcnt < TMP_SLOT_CYCLES;
    if (s.tcnt == TMP_SLOT_CYCLES - 1) begin
      next_s.tphase = ~s.tphase;
      if (s.tphase) begin
        next_s.t_result = temp_adc_data;
        next_s.t_fresh = 1'b1;
        next_s.ot_active = temp_adc_data > s.t_fault;
        if (temp_adc_data > s.t_warn) next_s.stat.twarn = 1'b1;
      end
    end

    // Power good qualification and enhancement grace
    pg_base = c.power_good_sense_in_ok & en_lvl & c.uv_ok & ~c.ov_hi & s.fault_n
      & (s.st == ST_ON);
    if (!pg_base) begin
      next_s.pg = 1'b0;
      next_s.enh_cnt = '0;
    end else if (c.enh_ok) begin
      next_s.pg = 1'b1;
      next_s.enh_cnt = '0;
    end else if (s.pg) begin
      if (s.enh_cnt == GRACE_CYCLES - 1) begin
        next_s.pg = 1'b0;
        fet_ev = 1'b1;
        next_s.enh_cnt = '0;
      end else begin
        next_s.enh_cnt = s.enh_cnt + 32'd1;
      end
    end

    // Shutdown causes
    oc_ev = (s.st == ST_ON) & c.timer_hi;
    ot_ev = (s.st == ST_ON) & s.ot_active;
    shut = oc_ev | fet_ev | ot_ev;
    if (shut) next_s.pg = 1'b0;
    start_ok = en_lvl & c.uv_ok & ~c.ov_hi & s.op_on & ~s.ot_active;

    // Supervisor state machine
    case (s.st)
      ST_OFF: begin
        if (start_ok && !pcyc) next_s.st = ST_ON;
      end
      ST_ON: begin
        if (shut) begin
          next_s.rearm = 1'b0;
          next_s.wcnt = '0;
          next_s.st = (oc_ev && !c.retry_n) ? ST_RETRY : ST_LATCH;
        end else if (!start_ok || pcyc) begin
          next_s.st = ST_OFF;
        end
      end
      ST_LATCH: begin
        if (uv_bad || !s.op_on || en_rise || pcyc) next_s.rearm = 1'b1;
        if (s.rearm && c.timer_lo) next_s.st = ST_OFF;
      end
      ST_RETRY: begin
        if (s.wcnt == RETRY_CYCLES - 1) next_s.st = ST_OFF;
        else next_s.wcnt = s.wcnt + 32'd1;
      end
      default: next_s.st = ST_OFF;
    endcase

    // Gate drive from the next state
    next_s.gate_on = next_s.st == ST_ON;
    if (next_s.st != ST_ON) next_s.pg = 1'b0;
    next_s.gate_spd = (next_s.st != ST_ON) & (uv_bad | ov_bad);
    next_s.gate_fpd = (next_s.st == ST_LATCH) | (next_s.st == ST_RETRY);

    // Fault pin: clear only with no active fault, a new fault wins
    if ((en_rise || (op_rise && s.st != ST_ON) || pcyc)
        && !(c.timer_hi || s.ot_active)) begin
      next_s.fault_n = 1'b1;
    end
    if (shut) next_s.fault_n = 1'b0;
    if (!next_s.fault_n) next_s.pg = 1'b0;
    next_s.pg_pull = ~next_s.pg;

    // Sticky status: clear by op rise or clear command, set wins
    if (clr_cmd || op_rise) next_s.stat = '0;
    if (uv_bad) next_s.stat.uv = 1'b1;
    if (ov_bad) next_s.stat.ov = 1'b1;
    if (oc_ev) next_s.stat.oc = 1'b1;
    if (fet_ev) next_s.stat.fet = 1'b1;
    if (ot_ev) next_s.stat.ot = 1'b1;
    if (next_s.sc_trip) next_s.stat.sc = 1'b1;
    if (s.tphase && s.tcnt == TMP_SLOT_CYCLES - 1 && temp_adc_data > s.t_warn) begin
      next_s.stat.twarn = 1'b1;
    end
    next_s.ready = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign gate_on = s.gate_on;
  assign gate_strong_pulldown = s.gate_spd;
  assign gate_fast_pulldown = s.gate_fpd;
  assign severe_oc_limit = s.sc_trip;
  assign fault_out_n = s.fault_n;
  assign power_good_out = 1'b0; // Open drain only ever pulls low
  assign power_good_out_oe = s.pg_pull;
  assign temp_adc_request = s.adc_req;

endmodule // hsfs_top

`default_nettype wire

/* pkg/hsfs_defines.svh */
// Constants of the hot swap fault supervisor: offsets, fields, resets, times.
// Assumes a 100 MHz bus clock; included by bare name.
`ifndef HSFS_DEFINES_SVH
`define HSFS_DEFINES_SVH

// Clock and times as printed
`define HSFS_CLK_HZ 100000000
`define HSFS_RETRY_S 10
`define HSFS_GRACE_MS 100
`define HSFS_TMP_PERIOD_MS 6
`define HSFS_TMP_SLOT_US 64
`define HSFS_SC_FILT_SHORT_NS 20
`define HSFS_SC_FILT_LONG_NS 500

// Register byte offsets
`define HSFS_OFS_CTRL 8'h00
`define HSFS_OFS_TFAULT 8'h04
`define HSFS_OFS_TWARN 8'h08
`define HSFS_OFS_TEMP 8'h0C
`define HSFS_OFS_STATUS 8'h10
`define HSFS_OFS_LIVE 8'h14

// Control register fields
`define HSFS_CTRL_OP 0
`define HSFS_CTRL_CLR 1
`define HSFS_CTRL_PCYC 2
`define HSFS_CTRL_THR_LSB 3
`define HSFS_CTRL_FILT 5

// Temperature result fresh flag position
`define HSFS_TEMP_FRESH 12

// Reset values
`define HSFS_RST_OP 1'b1
`define HSFS_RST_TFAULT 12'hFFF
`define HSFS_RST_TWARN 12'hFFF

`endif

/* pkg/hsfs_pkg.sv */
// Types of the hot swap fault supervisor.
// Shared by the synchroniser and the top module.
package hsfs_pkg;

  // Supervisor states
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_LATCH, ST_RETRY} hsfs_state_t;

  // Sticky fault and warning flags, bit 0 is undervoltage
  typedef struct packed {
    logic sc;
    logic twarn;
    logic ot;
    logic fet;
    logic oc;
    logic ov;
    logic uv;
  } hsfs_status_t;

  // Comparator and pin levels crossing into the clock domain
  typedef struct packed {
    logic uv_ok;
    logic ov_hi;
    logic power_good_sense_in_ok;
    logic enh_ok;
    logic timer_hi;
    logic timer_lo;
    logic enable_raw;
    logic retry_n;
    logic [3:0] sc_cmp;
  } hsfs_pins_t;

endpackage

/* tb/hsfs_checker.sv */
// Port checker of the supervisor, bound into every top instance.
// Assumes one clock hclk and active low reset hresetn.
`timescale 1ns/10ps
`default_nettype none

module hsfs_checker import hsfs_pkg::*; #(
  parameter int unsigned RETRY_CYCLES = 200,
  parameter int unsigned GRACE_CYCLES = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic undervoltage_input,
  input wire logic overvoltage_input,
  input wire logic power_good_sense_in,
  input wire logic gate_enh_in,
  input wire logic timer_upper_threshold,
  input wire logic retry_strap_n,
  input wire logic [3:0] severe_oc_cmp,
  input wire logic gate_on,
  input wire logic gate_strong_pulldown,
  input wire logic gate_fast_pulldown,
  input wire logic severe_oc_limit,
  input wire logic fault_out_n,
  input wire logic power_good_out,
  input wire logic power_good_out_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int unsigned enh_cnt;
  int unsigned fp_cnt;
  int unsigned sc_cnt;
  // Run lengths of lost enhancement, fault pulldown and full comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enh_cnt <= 0;
      fp_cnt <= 0;
      sc_cnt <= 0;
    end else begin
      enh_cnt <= gate_enh_in ? 0 : enh_cnt + 1;
      fp_cnt <= gate_fast_pulldown ? fp_cnt + 1 : 0;
      sc_cnt <= (severe_oc_cmp == 4'hf) ? sc_cnt + 1 : 0;
    end
  end
  a_pg_open_drain: assert property (power_good_out == 1'b0) else $error("pg driven high");
  a_pg_needs_all: assert property (!power_good_out_oe |-> fault_out_n && gate_on)
    else $error("pg released without qualification");
  a_pg_drop_now: assert property (!power_good_sense_in [*4] |-> power_good_out_oe)
    else $error("pg not dropped on sense loss");
  a_pg_grace_end: assert property (enh_cnt > GRACE_CYCLES + 4 |-> power_good_out_oe)
    else $error("pg held past grace");
  a_uv_pulldown: assert property (
    !undervoltage_input [*4] |-> gate_strong_pulldown && !gate_on)
    else $error("undervoltage gate not pulled");
  a_ov_pulldown: assert property (
    overvoltage_input [*4] |-> gate_strong_pulldown && !gate_on)
    else $error("overvoltage gate not pulled");
  a_oc_shut: assert property (
    timer_upper_threshold [*3] ##0 gate_on |=> !gate_on && !fault_out_n)
    else $error("timer limit did not shut gate");
  a_fault_cause: assert property ($fell(fault_out_n) |-> gate_fast_pulldown)
    else $error("fault without shutdown");
  a_retry_wait: assert property ($fell(gate_fast_pulldown) && !retry_strap_n
    |-> fp_cnt >= RETRY_CYCLES - 1 && fp_cnt <= RETRY_CYCLES + 1)
    else $error("retry delay wrong");
  a_sc_limit: assert property (sc_cnt == 60 |-> severe_oc_limit)
    else $error("severe limit late");
endmodule // hsfs_checker

bind hsfs_top hsfs_checker #(.RETRY_CYCLES(RETRY_CYCLES), .GRACE_CYCLES(GRACE_CYCLES))
  i_hsfs_checker (.hclk(hclk), .hresetn(hresetn), .undervoltage_input(undervoltage_input),
  .overvoltage_input(overvoltage_input), .power_good_sense_in(power_good_sense_in),
  .gate_enh_in(gate_enh_in), .timer_upper_threshold(timer_upper_threshold),
  .retry_strap_n(retry_strap_n), .severe_oc_cmp(severe_oc_cmp), .gate_on(gate_on),
  .gate_strong_pulldown(gate_strong_pulldown), .gate_fast_pulldown(gate_fast_pulldown),
  .severe_oc_limit(severe_oc_limit), .fault_out_n(fault_out_n),
  .power_good_out(power_good_out), .power_good_out_oe(power_good_out_oe));

`default_nettype wire

/* tb/hsfs_partner.sv */
// Far side model: pass transistor, output rail, timer capacitor, strap.
// Assumes gate_on drives the transistor; controls come from the bench.
`timescale 1ns/10ps
`default_nettype none

module hsfs_partner (
  input wire logic hclk,
  input wire logic gate_on,
  input wire logic overload,
  input wire logic fet_bad,
  input wire logic strap_low,
  output logic power_good_sense_in,
  output logic gate_enh_in,
  output logic timer_upper_threshold,
  output logic timer_lower_threshold,
  output logic retry_strap_n
);
  int ramp = 0;
  int tmr = 0;
  // Output ramps up while the gate is on, timer charges under overload
  always @(posedge hclk) begin
    ramp <= gate_on ? ((ramp < 8) ? ramp + 1 : ramp) : 0;
    tmr <= (gate_on && overload) ? tmr + 1 : ((tmr > 0) ? tmr - 1 : 0);
  end
  assign power_good_sense_in = (ramp >= 8);
  assign gate_enh_in = (ramp >= 8) && !fet_bad;
  assign timer_upper_threshold = (tmr >= 10);
  assign timer_lower_threshold = (tmr < 2);
  // Unconnected strap reads high through the pull-up
  assign retry_strap_n = strap_low ? 1'b0 : 1'b1;
endmodule // hsfs_partner

`default_nettype wire

/* tb/hsfs_top_tb.sv */
// Self-checking bench of the supervisor with AHB-Lite master tasks.
// Assumes zero wait state slave and shortened timing parameters.
`timescale 1ns/10ps
`default_nettype none

module hsfs_top_tb;
  import hsfs_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, uv = 1, ov = 0, en = 1, overload = 0, fet_bad = 0, strap_low = 0;
  logic [3:0] sc = '0;
  logic [11:0] temp = 12'h000;
  logic pgs, enh, tup, tlo, rtn, gate_on, spd, fpd, scl, fault_n, pg, pg_oe, treq;
  int err_total = 0, total_checks = 0;
  int hi_cnt = 0, n_wait = 0;
  logic gate_low;
  logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h20};
  logic [31:0] rv [4] = '{32'h0000_0001, 32'h0000_0fff, 32'h0000_0fff, 32'h0000_0000};

  always #5 hclk = ~hclk;
  hsfs_top #(.RETRY_CYCLES(200), .GRACE_CYCLES(50), .TMP_PERIOD_CYCLES(400),
    .TMP_SLOT_CYCLES(20)) i_hsfs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .undervoltage_input(uv), .overvoltage_input(ov), .power_good_sense_in(pgs),
    .gate_enh_in(enh), .timer_upper_threshold(tup), .timer_lower_threshold(tlo),
    .enable_in(en), .retry_strap_n(rtn), .severe_oc_cmp(sc), .temp_adc_data(temp),
    .gate_on(gate_on), .gate_strong_pulldown(spd), .gate_fast_pulldown(fpd),
    .severe_oc_limit(scl), .fault_out_n(fault_n), .power_good_out(pg),
    .power_good_out_oe(pg_oe), .temp_adc_request(treq));
  hsfs_partner i_hsfs_partner (.hclk(hclk), .gate_on(gate_on), .overload(overload),
    .fet_bad(fet_bad), .strap_low(strap_low), .power_good_sense_in(pgs),
    .gate_enh_in(enh), .timer_upper_threshold(tup), .timer_lower_threshold(tlo),
    .retry_strap_n(rtn));
  // Active low enable variant, far side held quiet
  hsfs_top #(.ENABLE_ACTIVE_LOW(1'b1)) i_hsfs_top_low (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b0), .haddr(32'h0000_0000), .htrans(2'b00), .hwrite(1'b0), .hsize(3'h2),
    .hwdata(32'h0000_0000), .hready(1'b1), .hreadyout(), .hresp(), .hrdata(),
    .undervoltage_input(uv), .overvoltage_input(ov), .power_good_sense_in(1'b0),
    .gate_enh_in(1'b0), .timer_upper_threshold(1'b0), .timer_lower_threshold(1'b1),
    .enable_in(~en), .retry_strap_n(1'b1), .severe_oc_cmp(4'h0), .temp_adc_data(12'h000),
    .gate_on(gate_low), .gate_strong_pulldown(), .gate_fast_pulldown(), .severe_oc_limit(),
    .fault_out_n(), .power_good_out(), .power_good_out_oe(), .temp_adc_request());

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // One edge, then more while the slave stalls, bounded
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    rdy();
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic till_gate(input logic v);
    int n;
    n = 0;
    while (gate_on !== v && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (gate_on !== v) begin
      err_total++;
      summarize();
    end
    repeat (12) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    chk("fault reset", fault_n, 1);
    for (int i = 0; i < 4; i++) begin
      bus(0, ra[i], 0);
      chk("reg reset", r, rv[i]);
    end
    chk("hresp", hresp, 0);
    till_gate(1);
    chk("pg up", {pg, pg_oe}, 2'b00);
    // Overvoltage then undervoltage drop the gate with the strong pulldown
    for (int i = 0; i < 2; i++) begin
      if (i == 0) ov <= 1; else uv <= 0;
      repeat (5) @(posedge hclk);
      chk("supply pulldown", {spd, gate_on, pg_oe}, 3'b101);
      bus(0, 8'h10, 0);
      chk("supply status", r[1 - i], 1);
      ov <= 0;
      uv <= 1;
      till_gate(1);
    end
    // Lost enhancement holds power good, then health fault
    fet_bad <= 1;
    repeat (20) @(posedge hclk);
    chk("pg grace", pg_oe, 0);
    repeat (60) @(posedge hclk);
    chk("fet fault", {pg_oe, fault_n, gate_on}, 3'b100);
    fet_bad <= 0;
    en <= 0;
    repeat (20) @(posedge hclk);
    chk("enable off", gate_on, 0);
    chk("low enable off", gate_low, 0);
    en <= 1;
    till_gate(1);
    chk("enable clears", fault_n, 1);
    chk("low enable on", gate_low, 1);
    bus(0, 8'h10, 0);
    chk("status kept", r[3], 1);
    bus(1, 8'h00, 32'h0000_0003);
    bus(0, 8'h10, 0);
    chk("status clear", r, 0);
    // Each threshold select follows only its own comparator
    for (int s = 0; s < 4; s++) begin
      bus(1, 8'h00, {27'h0, s[1:0], 3'b001});
      sc <= 4'h1 << s;
      repeat (8) @(posedge hclk);
      chk("sc on", scl, 1);
      sc <= ~(4'h1 << s);
      repeat (8) @(posedge hclk);
      chk("sc off", scl, 0);
    end
    sc <= 4'hf;
    bus(1, 8'h00, 32'h0000_0021);
    repeat (30) @(posedge hclk);
    chk("long filter", scl, 0);
    repeat (40) @(posedge hclk);
    chk("long filter on", scl, 1);
    sc <= 0;
    // Overcurrent with strap low retries after the delay
    strap_low <= 1;
    overload <= 1;
    till_gate(0);
    overload <= 0;
    chk("oc fault", {fault_n, pg_oe, fpd}, 3'b011);
    repeat (100) @(posedge hclk);
    chk("retry wait", gate_on, 0);
    till_gate(1);
    chk("retry on", {gate_on, pg_oe}, 2'b11);
    bus(1, 8'h00, 32'h0000_0005);
    till_gate(1);
    chk("power cycle", fault_n, 1);
    // Overcurrent with strap floating latches off until op toggles
    strap_low <= 0;
    overload <= 1;
    till_gate(0);
    overload <= 0;
    repeat (300) @(posedge hclk);
    chk("latched", {gate_on, fault_n}, 2'b00);
    bus(1, 8'h00, 32'h0000_0000);
    bus(1, 8'h00, 32'h0000_0001);
    till_gate(1);
    chk("rearm", fault_n, 1);
    // Hot sample above the fault threshold shuts down
    bus(1, 8'h04, 32'h0000_0100);
    temp <= 12'h200;
    n_wait = 0;
    while (fault_n !== 1'b0 && n_wait < 1000) begin
      @(posedge hclk);
      n_wait++;
    end
    if (fault_n !== 1'b0) begin
      err_total++;
      summarize();
    end
    chk("overtemp", {fault_n, gate_on, pg_oe}, 3'b001);
    bus(0, 8'h0C, 0);
    chk("temp result", r[12:0], 13'h1200);
    // Any window of one period holds exactly one converter slot
    hi_cnt = 0;
    repeat (400) begin
      @(posedge hclk);
      hi_cnt += treq;
    end
    chk("adc slot", hi_cnt, 20);
    summarize();
  end
endmodule // hsfs_top_tb

`default_nettype wire
